/* src/pgb_map.svh */
// Register offsets, limits and raw-field biases for the pixel gain/offset balance block
`ifndef PGB_MAP_SVH
`define PGB_MAP_SVH

// Byte offsets; settings 0..7 at 0x00, raw view of the same at 0x20
`define PGB_SET_ABS_BASE 8'h00
`define PGB_SET_RAW_BASE 8'h20
`define PGB_MODE_ADDR 8'h40
`define PGB_MULT_BASE 8'h50

// Setting indexes
`define PGB_IDX_GAIN 3'h0
`define PGB_IDX_LR_GAIN 3'h1
`define PGB_IDX_LOE_GAIN 3'h2
`define PGB_IDX_ROE_GAIN 3'h3
`define PGB_IDX_OFFS 3'h4
`define PGB_IDX_LR_OFFS 3'h5
`define PGB_IDX_LOE_OFFS 3'h6
`define PGB_IDX_ROE_OFFS 3'h7

// Gains in 0.01 dB, offsets in 0.5 DN
`define PGB_GAIN_MIN -16'sh012C
`define PGB_GAIN_MAX 16'sh07D0
`define PGB_GBAL_MAX 16'sh0064
`define PGB_OFFS_MAX8 16'sh0190
`define PGB_OFFS_MAX10 16'sh0640
`define PGB_OBAL_MAX8 16'sh0028
`define PGB_OBAL_MAX10 16'sh00A0

// Mode register: bit 0 selects 10-bit output
`define PGB_MODE_10BIT_BIT 0
`define PGB_MODE_RESET 1'h0

// Output code ceilings
`define PGB_MAX8 10'h0FF
`define PGB_MAX10 10'h3FF

// log2(10)/20 per 0.01 dB in Q24; Q16 drifted a third of a percent at top gain
`define PGB_LOG2_K 16'h6CDA
// Fraction bits of the gain multiplier
`define PGB_MULT_FRAC 12

`endif

/* src/pgb_pkg.sv */
// Types shared by the pixel gain/offset balance block
package pgb_pkg;

  typedef logic signed [15:0] pgb_set_t;

  typedef logic [16:0] pgb_mult_t;

  typedef struct packed {
    logic vld;
    logic right;
    logic odd;
    logic [9:0] data;
  } pgb_pix_t;

  typedef struct packed {
    logic vld;
    logic [9:0] data;
  } pgb_out_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pgb_bus_t;

endpackage

/* src/pgb_db_mult.sv */
// Converts a gain in 0.01 dB to a linear multiplier, Q12
`timescale 1ns/100ps
`include "pgb_map.svh"
module pgb_db_mult (
  // Gain in 0.01 dB
  input wire pgb_pkg::pgb_set_t db,
  // Linear multiplier, 10^(dB/20)
  output logic [16:0] mult
);
  import pgb_pkg::*;

  // 2^(i/16) in Q12, one extra point for interpolation
  function automatic logic [13:0] exp2_tab(input logic [4:0] i);
    logic [13:0] t;
    t = 14'h1000;
    case (i)
      5'h00: t = 14'h1000;
      5'h01: t = 14'h10B5;
      5'h02: t = 14'h1173;
      5'h03: t = 14'h1238;
      5'h04: t = 14'h1306;
      5'h05: t = 14'h13DF;
      5'h06: t = 14'h14C0;
      5'h07: t = 14'h15AB;
      5'h08: t = 14'h16A1;
      5'h09: t = 14'h17A1;
      5'h0A: t = 14'h18AD;
      5'h0B: t = 14'h19C5;
      5'h0C: t = 14'h1AE9;
      5'h0D: t = 14'h1C1A;
      5'h0E: t = 14'h1D58;
      5'h0F: t = 14'h1EA5;
      default: t = 14'h2000;
    endcase
    return t;
  endfunction

  logic signed [27:0] log2_q24;
  logic signed [8:0] expo;
  logic [3:0] seg;
  logic [11:0] frac;
  logic [13:0] lo;
  logic [13:0] hi;
  logic [25:0] step;
  logic [13:0] mant;

  // Multiplier = 2^(dB * log2(10) / 20)
  assign log2_q24 = 28'(db * $signed({1'b0, `PGB_LOG2_K}));
  assign expo = {{5{log2_q24[27]}}, log2_q24[27:24]};
  assign seg = log2_q24[23:20];
  assign frac = log2_q24[19:8];
  assign lo = exp2_tab({1'b0, seg});
  assign hi = exp2_tab(5'({1'b0, seg} + 5'h01));
  // Linear interpolation keeps error near 0.01 dB without a large table
  assign step = 26'((hi - lo) * frac);
  assign mant = 14'(lo + 14'(step >> `PGB_MULT_FRAC));

  // Gain range -5..+22 dB keeps the exponent within -1..3
  always_comb begin
    if (expo[8]) begin
      mult = 17'(mant >> 1);
    end else begin
      mult = 17'({3'h0, mant} << expo[1:0]);
    end
  end

endmodule

/* src/pgb_core.sv */
// Pixel gain, offset and four-channel balance correction with register port
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "pgb_map.svh"
module pgb_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pixel stream in
  input wire pgb_pkg::pgb_pix_t pix_in,
  // Corrected pixel stream out
  output pgb_pkg::pgb_out_t pix_out,
  // Output width select, for the downstream formatter
  output logic mode_10bit
);
  import pgb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Upper bound of a setting in its own unit
  function automatic pgb_set_t set_max(input logic [2:0] idx, input logic m10);
    pgb_set_t v;
    v = `PGB_GBAL_MAX;
    case (idx)
      `PGB_IDX_GAIN: v = `PGB_GAIN_MAX;
      `PGB_IDX_LR_GAIN, `PGB_IDX_LOE_GAIN, `PGB_IDX_ROE_GAIN: v = `PGB_GBAL_MAX;
      `PGB_IDX_OFFS: v = m10 ? `PGB_OFFS_MAX10 : `PGB_OFFS_MAX8;
      default: v = m10 ? `PGB_OBAL_MAX10 : `PGB_OBAL_MAX8;
    endcase
    return v;
  endfunction

  // Lower bound; only the global gain is not symmetric
  function automatic pgb_set_t set_min(input logic [2:0] idx, input logic m10);
    pgb_set_t v;
    v = -set_max(idx, m10);
    if (idx == `PGB_IDX_GAIN) begin
      v = `PGB_GAIN_MIN;
    end
    return v;
  endfunction

  function automatic pgb_set_t clamp_set(input logic signed [17:0] v, input logic [2:0] idx,
                                         input logic m10);
    pgb_set_t lo;
    pgb_set_t hi;
    pgb_set_t r;
    lo = set_min(idx, m10);
    hi = set_max(idx, m10);
    r = v[15:0];
    if (v < 18'(lo)) begin
      r = lo;
    end else if (v > 18'(hi)) begin
      r = hi;
    end
    return r;
  endfunction

  // Global value plus left/right trim plus the side's odd/even trim
  function automatic pgb_set_t chan_sum(input pgb_set_t glob, input pgb_set_t lr,
                                        input pgb_set_t loe, input pgb_set_t roe,
                                        input logic right, input logic odd);
    pgb_set_t side_t;
    pgb_set_t oe_t;
    side_t = right ? -lr : lr;
    if (right) begin
      oe_t = odd ? roe : -roe;
    end else begin
      oe_t = odd ? loe : -loe;
    end
    return 16'(glob + side_t + oe_t);
  endfunction

  // Address decodes; the setting and mode ones are shared by the write and read paths
  function automatic logic is_set_addr(input logic [7:0] a);
    return (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_mode_addr(input logic [7:0] a);
    return a == `PGB_MODE_ADDR;
  endfunction

  // Multiplier readback window, four words
  function automatic logic is_mult_addr(input logic [7:0] a);
    return (a[7:4] == 4'(`PGB_MULT_BASE >> 4)) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  pgb_set_t set_reg [8];
  logic mode_reg;
  logic [31:0] rdata_reg;
  logic [2:0] wr_idx;
  logic wr_raw;
  logic wr_set;
  logic signed [17:0] wr_value;

  assign wr_idx = reg_addr[4:2];
  assign wr_raw = reg_addr[5];
  assign wr_set = reg_wr && is_set_addr(reg_addr);

  // Raw field is the unsigned count of steps above the setting's minimum
  always_comb begin
    if (wr_raw) begin
      wr_value = 18'($signed({2'h0, reg_wdata[15:0]}) + 18'(set_min(wr_idx, mode_reg)));
    end else begin
      wr_value = 18'($signed(reg_wdata[15:0]));
    end
  end

  // Out-of-range writes clamp rather than fault
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        set_reg[i] <= 16'sh0000;
      end
    end else if (wr_set) begin
      set_reg[wr_idx] <= clamp_set(wr_value, wr_idx, mode_reg);
    end
  end

  // Stored settings are not re-clamped when the width changes
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `PGB_MODE_RESET;
    end else if (reg_wr && is_mode_addr(reg_addr)) begin
      mode_reg <= reg_wdata[`PGB_MODE_10BIT_BIT];
    end
  end

  assign mode_10bit = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel multipliers

  // One converter shared round-robin; a new gain lands within four cycles
  logic [1:0] conv_sel_reg;
  pgb_set_t conv_db;
  logic [16:0] conv_mult;
  logic [16:0] mult_reg [4];

  assign conv_db = chan_sum(set_reg[`PGB_IDX_GAIN], set_reg[`PGB_IDX_LR_GAIN],
                            set_reg[`PGB_IDX_LOE_GAIN], set_reg[`PGB_IDX_ROE_GAIN],
                            conv_sel_reg[1], conv_sel_reg[0]);

  pgb_db_mult u_db_mult (
    .db(conv_db),
    .mult(conv_mult)
  );

  // Free-running, so no write has to trigger a refresh
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_sel_reg <= 2'h0;
    end else begin
      conv_sel_reg <= 2'(conv_sel_reg + 2'h1);
    end
  end

  // Unity gain until the converter has made its first pass
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        mult_reg[i] <= 17'h0_1000;
      end
    end else begin
      mult_reg[conv_sel_reg] <= conv_mult;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  logic [31:0] rdata_next;

  // Unmapped addresses read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (is_set_addr(reg_addr)) begin
      if (wr_raw) begin
        rdata_next = {16'h0000, 16'(set_reg[wr_idx] - set_min(wr_idx, mode_reg))};
      end else begin
        rdata_next = {{16{set_reg[wr_idx][15]}}, set_reg[wr_idx]};
      end
    end else if (is_mode_addr(reg_addr)) begin
      rdata_next = {31'h0000_0000, mode_reg};
    end else if (is_mult_addr(reg_addr)) begin
      rdata_next = {15'h0000, mult_reg[reg_addr[3:2]]};
    end
  end

  // Read data stand until the next read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel pipeline, stage 1: gain multiply and offset select

  logic [26:0] prod_reg;
  logic signed [15:0] offs_reg;
  logic vld1_reg;
  logic [9:0] in_data;

  // In 8-bit mode only the low byte of the sample is meaningful
  assign in_data = mode_reg ? pix_in.data : {2'h0, pix_in.data[7:0]};

  // No back-pressure: every valid pixel leaves two cycles later
  always_ff @(posedge clk) begin
    if (rst) begin
      vld1_reg <= 1'b0;
    end else begin
      vld1_reg <= pix_in.vld;
    end
  end

  // Data path only moves with a valid pixel, saving toggles
  always_ff @(posedge clk) begin
    if (rst) begin
      prod_reg <= 27'h000_0000;
      offs_reg <= 16'sh0000;
    end else if (pix_in.vld) begin
      prod_reg <= 27'(in_data * mult_reg[{pix_in.right, pix_in.odd}]);
      offs_reg <= chan_sum(set_reg[`PGB_IDX_OFFS], set_reg[`PGB_IDX_LR_OFFS],
                           set_reg[`PGB_IDX_LOE_OFFS], set_reg[`PGB_IDX_ROE_OFFS],
                           pix_in.right, pix_in.odd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: add offset, round, saturate

  logic signed [19:0] acc_half;
  logic signed [19:0] acc_dn;
  logic [9:0] out_max;
  logic [9:0] sat_val;

  // Product kept in half-DN so the 0.5 DN offset step is not lost
  assign acc_half = 20'($signed({4'h0, prod_reg[26:(`PGB_MULT_FRAC - 1)]})) + 20'(offs_reg);
  assign acc_dn = (acc_half + 20'sh0_0001) >>> 1;
  assign out_max = mode_reg ? `PGB_MAX10 : `PGB_MAX8;

  always_comb begin
    if (acc_dn < 20'sh0_0000) begin
      sat_val = 10'h000;
    end else if (acc_dn > 20'($signed({10'h000, out_max}))) begin
      sat_val = out_max;
    end else begin
      sat_val = acc_dn[9:0];
    end
  end

  pgb_out_t out_reg;

  // Data hold between pixels; only the valid bit pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg.vld <= vld1_reg;
      if (vld1_reg) begin
        out_reg.data <= sat_val;
      end
    end
  end

  assign pix_out = out_reg;

endmodule

/* testbench/pgb_core_checker.sv */
// Port checker for the pixel correction core
`timescale 1ns/100ps
module pgb_core_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pixel streams
  input wire pgb_pkg::pgb_pix_t pix_in,
  input wire pgb_pkg::pgb_out_t pix_out,
  input wire logic mode_10bit
);
  import pgb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  pix_lat_a: assert property (pix_in.vld |-> ##2 pix_out.vld)
    else $error("pixel not answered");
  no_spur_a: assert property (pix_out.vld |-> $past(pix_in.vld, 2))
    else $error("output without input");
  sat_eight_a: assert property (pix_out.vld && !mode_10bit |-> pix_out.data[9:8] == 2'h0)
    else $error("8-bit output too large");
  mode_set_a: assert property (reg_wr && reg_addr == 8'h40 |=> mode_10bit == $past(reg_wdata[0]))
    else $error("mode write lost");
  mode_keep_a: assert property (!(reg_wr && reg_addr == 8'h40) |=> $stable(mode_10bit))
    else $error("mode changed alone");
  unmap_rd_a: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  mode_rd_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == {31'h0, mode_10bit})
    else $error("mode readback wrong");
  rst_zero_a: assert property (disable iff (1'b0) rst |=> !pix_out.vld && !mode_10bit && reg_rdata == 0)
    else $error("reset values wrong");
  cover property (pix_out.vld && !mode_10bit && pix_out.data == 10'h0FF);
  cover property (pix_out.vld && mode_10bit);
  cover property (reg_rd && reg_addr == 8'h50);
endmodule

bind pgb_core pgb_core_checker u_pgb_core_checker (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in),
  .pix_out(pix_out), .mode_10bit(mode_10bit));

/* testbench/pgb_grabber.sv */
// Frame grabber model collecting corrected pixels
`timescale 1ns/100ps
module pgb_grabber (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Corrected stream
  input wire pgb_pkg::pgb_out_t pix
);
  import pgb_pkg::*;
  logic [9:0] got_q[$];
  // No back-pressure on this link, so every valid beat is kept
  always @(posedge clk) begin
    if (rst) begin
      got_q.delete();
    end else if (pix.vld) begin
      got_q.push_back(pix.data);
    end
  end
endmodule

/* testbench/pgb_core_tb.sv */
// Randomised self-checking bench for the pixel correction core
`timescale 1ns/100ps
module pgb_core_tb;
  import pgb_pkg::*;
  logic clk, rst, reg_wr, reg_rd, mode_10bit;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  pgb_pix_t pix_in;
  pgb_out_t pix_out;
  int errors = 0, n_checks = 0, seed, m10, sv[8], q_exp[$];
  pgb_core u_pgb_core (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out), .mode_10bit(mode_10bit));
  pgb_grabber u_pgb_grabber (.clk(clk), .rst(rst), .pix(pix_out));
  ////////////////////////////////////////
  function automatic int hi(int i);
    return i == 0 ? 2000 : i < 4 ? 100 : i == 4 ? (m10 ? 1600 : 400) : (m10 ? 160 : 40);
  endfunction
  function automatic int lo(int i);
    return i == 0 ? -300 : -hi(i);
  endfunction
  // Channel code: bit 1 right half, bit 0 odd pixel
  function automatic real mul(int c);
    int s = c[1] ? -1 : 1;
    int t = c[0] ? 1 : -1;
    return 4096.0 * $pow(10.0, (sv[0] + s * sv[1] + t * sv[c[1] ? 3 : 2]) / 2000.0);
  endfunction
  function automatic int px(int c, int x);
    int s = c[1] ? -1 : 1;
    int t = c[0] ? 1 : -1;
    int h = int'($floor(x * mul(c) / 2048.0)) + sv[4] + s * sv[5] + t * sv[c[1] ? 7 : 6];
    h = (h + 1) >>> 1;
    return h < 0 ? 0 : h > (m10 ? 1023 : 255) ? (m10 ? 1023 : 255) : h;
  endfunction
  task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Gain maths is approximated in the core, so these allow a margin
  task automatic chk_near(logic [31:0] got, int exp, int tol);
    n_checks++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic put(int i, int v, bit raw);
    int c = v < lo(i) ? lo(i) : v > hi(i) ? hi(i) : v;
    sv[i] = c;
    if (raw) wr(8'h20 + 8'(4 * i), 32'(c - lo(i)));
    else wr(8'(4 * i), 32'(v));
    rd(8'(4 * i));
    chk_reg(d, 32'(c));
    rd(8'h20 + 8'(4 * i));
    chk_reg(d, 32'(c - lo(i)));
  endtask
  task automatic burst(int n);
    int c, x;
    for (int j = 0; j < n; j++) begin
      c = $random(seed) & 3;
      x = j < 2 ? j * (m10 ? 1023 : 255) : $random(seed) & (m10 ? 1023 : 255);
      q_exp.push_back(px(c, x));
      @(posedge clk);
      pix_in <= '{1'b1, c[1], c[0], 10'(x)};
    end
    @(posedge clk);
    pix_in <= '0;
    repeat (3) @(posedge clk);
    #1 chk_reg(32'(u_pgb_grabber.got_q.size()), 32'(n));
    while (q_exp.size() > 0) begin
      chk_near(32'(u_pgb_grabber.got_q.pop_front()), q_exp.pop_front(), 1);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    seed = 78328;
    m10 = 0;
    sv = '{default: 0};
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    pix_in = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(i == 8 ? 8'h60 : 8'(4 * i));
      chk_reg(d, 32'h0000_0000);
    end
    for (int c = 0; c < 4; c++) begin
      rd(8'h50 + 8'(4 * c));
      chk_reg(d, 32'h0000_1000);
    end
    for (int p = 0; p < 8; p++) begin
      m10 = p & 1;
      wr(8'h40, 32'(m10));
      rd(8'h40);
      chk_reg(d, 32'(m10));
      chk_reg(32'(mode_10bit), 32'(m10));
      for (int i = 0; i < 8; i++) begin
        put(i, p == 2 ? hi(i) + 9 : p == 3 ? lo(i) - 9 : $random(seed) % (hi(i) * 3 / 2), p > 3 && i[0]);
      end
      // Multipliers are refreshed round-robin after a write
      repeat (6) @(posedge clk);
      for (int c = 0; c < 4; c++) begin
        rd(8'h50 + 8'(4 * c));
        chk_near(d, int'(mul(c)), int'(mul(c) / 500.0) + 2);
      end
      burst(16 + p);
    end
    end_of_test();
  end
endmodule
